// ### src/bacu_pkg.sv
// Function
// - compare result in bit zero, rest cleared
// - address equal, unequal, less, greater-or-equal compares
// - address register zero and nonzero tests
// - branch decided by own compare, no flags
// - plain jump loads program counter only
// - jump with link also writes return address
// - call saves caller context to save area
// - return jumps back and restores saved context
// - relative, absolute and register target forms
// - short relative, indirect and return encodings
// - unconditional offsets are doubled before use
// - branch offsets doubled then sign-extended to 32
// - data register compare branches, 15-bit offset
// - implicit register zero or nonzero, 8-bit
// - implicit register against 4-bit signed constant
// - any data register against zero, 4-bit
// - address register compare branches, 15-bit offset
// - short address zero or nonzero branches
// - branch on single bit clear or set
// - not-equal branch then count first operand
// - hardware loop costs cycles first, last only
// - loop offsets: 15-bit signed, 4-bit one-extended
package bacu_pkg;

  // ----------------------------------------------------------------
  // widths and values
  // ----------------------------------------------------------------
  localparam int unsigned XLEN        = 32;
  localparam int unsigned REL24_W     = 24;
  localparam int unsigned REL15_W     = 15;
  localparam int unsigned REL8_W      = 8;
  localparam int unsigned REL4_W      = 4;
  localparam int unsigned CONST_W     = 4;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [31:0] LONG_STEP   = 32'h0000_0004;
  localparam logic [31:0] SHORT_STEP  = 32'h0000_0002;
  localparam logic [31:0] COUNT_STEP  = 32'h0000_0001;
  localparam logic [1:0]  LOOP_BUSY_CYC = 2'h1;
  localparam logic [1:0]  LOOP_FREE_CYC = 2'h0;

  // ----------------------------------------------------------------
  // operations and target forms
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NONE, OP_ADDR_EQUAL_CMP, OP_ADDR_NOTEQUAL_CMP, OP_ADDR_LESS_CMP,
    OP_ADDR_GREATER_EQUAL_CMP, OP_ADDR_IS_ZERO_TEST, OP_ADDR_IS_NONZERO_TEST,
    OP_JUMP, OP_JUMP_LINK, OP_CALL, OP_CALL_RETURN, OP_EXCEPTION_RETURN,
    OP_BRANCH_IF_EQUAL, OP_BRANCH_IF_NOT_EQUAL, OP_BRANCH_IF_LESS_SIGNED,
    OP_BRANCH_IF_LESS_UNSIGNED, OP_BRANCH_IF_GE_SIGNED, OP_BRANCH_IF_GE_UNSIGNED,
    OP_BRANCH_IF_ZERO, OP_BRANCH_IF_NONZERO, OP_BRANCH_IF_NEGATIVE,
    OP_BRANCH_IF_NOT_POSITIVE, OP_BRANCH_IF_POSITIVE, OP_BRANCH_IF_NOT_NEGATIVE,
    OP_BRANCH_IF_ADDR_EQUAL, OP_BRANCH_IF_ADDR_NOT_EQUAL, OP_BRANCH_IF_ADDR_ZERO,
    OP_BRANCH_IF_ADDR_NONZERO, OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_IF_BIT_SET,
    OP_BRANCH_NE_THEN_INCREMENT, OP_BRANCH_NE_THEN_DECREMENT, OP_LOOP
  } bacu_op_type;

  typedef enum logic [2:0] {
    DF_REL24, DF_ABS24, DF_REG, DF_REL15, DF_REL8, DF_REL4, DF_LOOP4
  } bacu_dfmt_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SAVE = 3'b010,
    ST_REST = 3'b100
  } bacu_state_type;

  typedef struct packed {
    bacu_op_type   op;
    bacu_dfmt_type dfmt;
    logic          short_insn;
    logic          use_implicit;
    logic          use_const;
    logic [3:0]    const4;
    logic [4:0]    bitpos;
    logic [23:0]   disp;
    logic [31:0]   pc;
    logic [31:0]   opa;
    logic [31:0]   opb;
  } bacu_req_type;

  // doubled field of width w, filled above with fill
  function automatic logic [31:0] bacu_scale_ext(input logic [23:0] f,
                                                 input int unsigned w,
                                                 input logic fill);
    logic [31:0] r;
    r = {32{fill}};
    for (int i = 0; i < 24; i++)
    begin
      if (i < w)
        r[i+1] = f[i];
    end
    r[0] = 1'b0;
    return r;
  endfunction : bacu_scale_ext

endpackage : bacu_pkg

// ### src/bacu_cond.sv
`timescale 1ns/10ps
module bacu_cond
  import bacu_pkg::*;
(
  input  wire bacu_op_type op_i,
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  input  wire logic [4:0]  bitpos_i,
  output logic             take_o
);
  // ----------------------------------------------------------------
  // boolean outcome, computed fresh for every operation
  // ----------------------------------------------------------------
  logic a_zero;
  assign a_zero = (a_i == RST_WORD);

  // one comparator set serves both compares and branches
  always_comb
  begin
    take_o = 1'b0;
    unique case (op_i)
      OP_ADDR_EQUAL_CMP,
      OP_BRANCH_IF_EQUAL,
      OP_BRANCH_IF_ADDR_EQUAL:       take_o = (a_i == b_i);
      OP_ADDR_NOTEQUAL_CMP,
      OP_BRANCH_IF_NOT_EQUAL,
      OP_BRANCH_IF_ADDR_NOT_EQUAL,
      OP_BRANCH_NE_THEN_INCREMENT,
      OP_BRANCH_NE_THEN_DECREMENT:   take_o = (a_i != b_i);
      OP_ADDR_LESS_CMP,
      OP_BRANCH_IF_LESS_UNSIGNED:    take_o = (a_i < b_i);
      OP_ADDR_GREATER_EQUAL_CMP,
      OP_BRANCH_IF_GE_UNSIGNED:      take_o = (a_i >= b_i);
      OP_BRANCH_IF_LESS_SIGNED:      take_o = ($signed(a_i) < $signed(b_i));
      OP_BRANCH_IF_GE_SIGNED:        take_o = ($signed(a_i) >= $signed(b_i));
      OP_ADDR_IS_ZERO_TEST,
      OP_BRANCH_IF_ZERO,
      OP_BRANCH_IF_ADDR_ZERO:        take_o = a_zero;
      OP_ADDR_IS_NONZERO_TEST,
      OP_BRANCH_IF_NONZERO,
      OP_BRANCH_IF_ADDR_NONZERO,
      OP_LOOP:                       take_o = !a_zero;
      OP_BRANCH_IF_NEGATIVE:         take_o = a_i[31];
      OP_BRANCH_IF_NOT_POSITIVE:     take_o = a_i[31] || a_zero;
      OP_BRANCH_IF_POSITIVE:         take_o = !a_i[31] && !a_zero;
      OP_BRANCH_IF_NOT_NEGATIVE:     take_o = !a_i[31];
      OP_BRANCH_IF_BIT_CLEAR:        take_o = !a_i[bitpos_i];
      OP_BRANCH_IF_BIT_SET:          take_o = a_i[bitpos_i];
      default:                       take_o = 1'b0;
    endcase
  end

endmodule : bacu_cond

// ### src/bacu_target.sv
`timescale 1ns/10ps
module bacu_target
  import bacu_pkg::*;
(
  input  wire bacu_dfmt_type dfmt_i,
  input  wire logic [31:0]   pc_i,
  input  wire logic [23:0]   disp_i,
  input  wire logic [31:0]   opa_i,
  output logic [31:0]        target_o
);
  // ----------------------------------------------------------------
  // target address forming
  // ----------------------------------------------------------------
  // offsets are doubled, and bit zero is cleared for absolute and register targets; relative targets keep bit zero of pc
  always_comb
  begin
    target_o = RST_WORD;
    unique case (dfmt_i)
      DF_REL24: target_o = pc_i + bacu_scale_ext(disp_i, REL24_W, disp_i[23]);
      DF_ABS24: target_o = {7'h00, disp_i, 1'b0};
      DF_REG:   target_o = {opa_i[31:1], 1'b0};
      DF_REL15: target_o = pc_i + bacu_scale_ext(disp_i, REL15_W, disp_i[14]);
      DF_REL8:  target_o = pc_i + bacu_scale_ext(disp_i, REL8_W, disp_i[7]);
      DF_REL4:  target_o = pc_i + bacu_scale_ext(disp_i, REL4_W, disp_i[3]);
      DF_LOOP4: target_o = pc_i + bacu_scale_ext(disp_i, REL4_W, 1'b1);
      default:  target_o = RST_WORD;
    endcase
  end

endmodule : bacu_target

// ### src/bacu_unit.sv
`timescale 1ns/10ps
module bacu_unit
  import bacu_pkg::*;
(
  input  wire logic         sys_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic         req_valid_i,
  input  wire bacu_req_type req_i,
  input  wire logic [31:0]  implicit_data_register_i,
  input  wire logic [31:0]  return_address_register_i,
  input  wire logic         ctx_done_i,
  output logic              req_ready_o,
  output logic              busy_o,
  output logic              data_wr_o,
  output logic [31:0]       data_val_o,
  output logic              addr_wr_o,
  output logic [31:0]       addr_val_o,
  output logic              link_wr_o,
  output logic [31:0]       link_val_o,
  output logic              redirect_o,
  output logic [31:0]       redirect_pc_o,
  output logic              ctx_save_req_o,
  output logic              ctx_restore_req_o,
  output logic              ctx_exception_o,
  output logic              done_o,
  output logic [1:0]        loop_cycles_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  bacu_state_type state_reg;
  bacu_state_type state_next;
  logic        accept;
  logic [31:0] opa_sel;
  logic [31:0] opb_sel;
  logic        take;
  logic [31:0] target;
  logic [31:0] next_pc;
  logic        is_cmp;
  logic        is_branch;
  logic        is_count;
  logic        is_jump;
  logic        is_link;
  logic        is_call;
  logic        is_ret;
  logic        is_loop;
  logic        data_wr_reg;
  logic [31:0] data_val_reg;
  logic        addr_wr_reg;
  logic [31:0] addr_val_reg;
  logic        link_wr_reg;
  logic [31:0] link_val_reg;
  logic        redirect_reg;
  logic [31:0] redirect_pc_reg;
  logic        save_req_reg;
  logic        restore_req_reg;
  logic        exc_reg;
  logic        done_reg;
  logic [1:0]  loop_cyc_reg;
  logic [31:0] held_target_reg;
  logic [31:0] held_link_reg;
  logic        loop_armed_reg;
  logic [31:0] loop_pc_reg;
  logic        loop_repeat;
  logic        ctx_finish;

  // ----------------------------------------------------------------
  // request acceptance
  // ----------------------------------------------------------------
  // only one context transfer in flight; new work waits for it
  assign req_ready_o = (state_reg == ST_IDLE);
  assign busy_o      = !req_ready_o;
  assign accept      = ce_i && req_valid_i && req_ready_o;
  assign ctx_finish  = ce_i && ctx_done_i && !req_ready_o;

  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  // short forms name the implicit data register without a field
  assign opa_sel = req_i.use_implicit ? implicit_data_register_i : req_i.opa;

  // short constant compare takes a sign-extended nibble
  assign opb_sel = req_i.use_const ?
                   {{(XLEN-CONST_W){req_i.const4[3]}}, req_i.const4} :
                   req_i.opb;

  // address of the instruction after this one
  assign next_pc = req_i.pc + (req_i.short_insn ? SHORT_STEP : LONG_STEP);

  // ----------------------------------------------------------------
  // operation classes
  // ----------------------------------------------------------------
  always_comb
  begin
    is_cmp    = 1'b0;
    is_branch = 1'b0;
    is_count  = 1'b0;
    is_jump   = 1'b0;
    is_link   = 1'b0;
    is_call   = 1'b0;
    is_ret    = 1'b0;
    is_loop   = 1'b0;
    unique case (req_i.op)
      OP_ADDR_EQUAL_CMP,
      OP_ADDR_NOTEQUAL_CMP,
      OP_ADDR_LESS_CMP,
      OP_ADDR_GREATER_EQUAL_CMP,
      OP_ADDR_IS_ZERO_TEST,
      OP_ADDR_IS_NONZERO_TEST:
        is_cmp = 1'b1;
      OP_JUMP:
        is_jump = 1'b1;
      OP_JUMP_LINK:
        is_link = 1'b1;
      OP_CALL:
        is_call = 1'b1;
      OP_CALL_RETURN,
      OP_EXCEPTION_RETURN:
        is_ret = 1'b1;
      OP_BRANCH_NE_THEN_INCREMENT,
      OP_BRANCH_NE_THEN_DECREMENT:
        is_count = 1'b1;
      OP_LOOP:
        is_loop = 1'b1;
      OP_NONE:
        is_cmp = 1'b0;
      default:
        is_branch = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // condition and target datapaths
  // ----------------------------------------------------------------
  bacu_cond u_cond (
    .op_i     (req_i.op),
    .a_i      (opa_sel),
    .b_i      (opb_sel),
    .bitpos_i (req_i.bitpos),
    .take_o   (take)
  );

  bacu_target u_target (
    .dfmt_i   (req_i.dfmt),
    .pc_i     (req_i.pc),
    .disp_i   (req_i.disp),
    .opa_i    (opa_sel),
    .target_o (target)
  );

  // ----------------------------------------------------------------
  // context transfer sequencing
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (accept && is_call)
          state_next = ST_SAVE;
        else if (accept && is_ret)
          state_next = ST_REST;
      end
      ST_SAVE,
      ST_REST:
      begin
        if (ctx_done_i)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      state_reg <= ST_IDLE;
    else if (ce_i)
      state_reg <= state_next;
  end

  // ----------------------------------------------------------------
  // held jump data across a context transfer
  // ----------------------------------------------------------------
  // return target is the link value as it stood at the request
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      held_target_reg <= RST_WORD;
      held_link_reg   <= RST_WORD;
      exc_reg         <= 1'b0;
    end
    else if (accept && (is_call || is_ret))
    begin
      held_target_reg <= is_ret ? {return_address_register_i[31:1], 1'b0} : target;
      held_link_reg   <= next_pc;
      exc_reg         <= (req_i.op == OP_EXCEPTION_RETURN);
    end
  end

  // ----------------------------------------------------------------
  // context request strobes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      save_req_reg    <= 1'b0;
      restore_req_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      save_req_reg    <= accept && is_call;
      restore_req_reg <= accept && is_ret;
    end
  end

  // ----------------------------------------------------------------
  // data register write-back
  // ----------------------------------------------------------------
  // compare results fill bit zero only; counters write the new count
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      data_wr_reg  <= 1'b0;
      data_val_reg <= RST_WORD;
    end
    else if (ce_i)
    begin
      data_wr_reg <= accept && (is_cmp || is_count);
      if (accept && is_cmp)
        data_val_reg <= {31'h0000_0000, take};
      else if (accept && req_i.op == OP_BRANCH_NE_THEN_INCREMENT)
        data_val_reg <= opa_sel + COUNT_STEP;
      else if (accept && req_i.op == OP_BRANCH_NE_THEN_DECREMENT)
        data_val_reg <= opa_sel - COUNT_STEP;
    end
  end

  // ----------------------------------------------------------------
  // loop count write-back
  // ----------------------------------------------------------------
  // the count is not touched on the final pass, so it ends at zero
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      addr_wr_reg  <= 1'b0;
      addr_val_reg <= RST_WORD;
    end
    else if (ce_i)
    begin
      addr_wr_reg <= accept && is_loop && take;
      if (accept && is_loop && take)
        addr_val_reg <= opa_sel - COUNT_STEP;
    end
  end

  // ----------------------------------------------------------------
  // return address write
  // ----------------------------------------------------------------
  // a call writes the link only once its context is safely stored
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      link_wr_reg  <= 1'b0;
      link_val_reg <= RST_WORD;
    end
    else if (ce_i)
    begin
      link_wr_reg <= (accept && is_link) || (ctx_finish && state_reg == ST_SAVE);
      if (accept && is_link)
        link_val_reg <= next_pc;
      else if (ctx_finish && state_reg == ST_SAVE)
        link_val_reg <= held_link_reg;
    end
  end

  // ----------------------------------------------------------------
  // program counter redirect
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      redirect_reg    <= 1'b0;
      redirect_pc_reg <= RST_WORD;
    end
    else if (ce_i)
    begin
      if (accept && (is_jump || is_link))
      begin
        redirect_reg    <= 1'b1;
        redirect_pc_reg <= target;
      end
      else if (accept && (is_branch || is_count || is_loop))
      begin
        redirect_reg    <= take;
        redirect_pc_reg <= take ? target : next_pc;
      end
      else if (ctx_finish)
      begin
        redirect_reg    <= 1'b1;
        redirect_pc_reg <= held_target_reg;
      end
      else
        redirect_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // completion strobe
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      done_reg <= 1'b0;
    else if (ce_i)
      done_reg <= (accept && !is_call && !is_ret) || ctx_finish;
  end

  // ----------------------------------------------------------------
  // zero-overhead loop tracker
  // ----------------------------------------------------------------
  // one loop is remembered; a nested loop at another address rearms
  // the tracker, so only the innermost loop runs for free
  assign loop_repeat = loop_armed_reg && (loop_pc_reg == req_i.pc);

  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
    begin
      loop_armed_reg <= 1'b0;
      loop_pc_reg    <= RST_WORD;
    end
    else if (accept && is_loop)
    begin
      loop_armed_reg <= take;
      loop_pc_reg    <= req_i.pc;
    end
  end

  // first and final passes cost a cycle, middle passes none
  always_ff @(posedge sys_clk_i)
  begin
    if (!nrst_i)
      loop_cyc_reg <= LOOP_FREE_CYC;
    else if (ce_i)
    begin
      if (accept && is_loop)
        loop_cyc_reg <= (loop_repeat && take) ? LOOP_FREE_CYC : LOOP_BUSY_CYC;
      else
        loop_cyc_reg <= LOOP_FREE_CYC;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign data_wr_o         = data_wr_reg;
  assign data_val_o        = data_val_reg;
  assign addr_wr_o         = addr_wr_reg;
  assign addr_val_o        = addr_val_reg;
  assign link_wr_o         = link_wr_reg;
  assign link_val_o        = link_val_reg;
  assign redirect_o        = redirect_reg;
  assign redirect_pc_o     = redirect_pc_reg;
  assign ctx_save_req_o    = save_req_reg;
  assign ctx_restore_req_o = restore_req_reg;
  assign ctx_exception_o   = exc_reg;
  assign done_o            = done_reg;
  assign loop_cycles_o     = loop_cyc_reg;

endmodule : bacu_unit

// ### verification/bacu_unit_assertions.sv
`timescale 1ns/10ps
module bacu_unit_sva
  import bacu_pkg::*;
(
  input wire logic         sys_clk_i,
  input wire logic         nrst_i,
  input wire logic         ce_i,
  input wire logic         req_valid_i,
  input wire bacu_req_type req_i,
  input wire logic         req_ready_o,
  input wire logic         data_wr_o,
  input wire logic [31:0]  data_val_o,
  input wire logic         addr_wr_o,
  input wire logic [31:0]  addr_val_o,
  input wire logic         link_wr_o,
  input wire logic [31:0]  link_val_o,
  input wire logic         redirect_o,
  input wire logic [31:0]  redirect_pc_o,
  input wire logic         ctx_save_req_o,
  input wire logic         ctx_restore_req_o
);
  // ----------------------------------------------------------------
  // request capture
  // ----------------------------------------------------------------
  // taken request, and one whose operands come straight from req_i
  logic tk;
  logic pl;
  assign tk = ce_i && req_valid_i && req_ready_o;
  assign pl = !req_i.use_implicit && !req_i.use_const;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_cmp;
    tk && req_i.op inside {[OP_ADDR_EQUAL_CMP:OP_ADDR_IS_NONZERO_TEST]}
      |=> data_wr_o && data_val_o[31:1] == 31'h0;
  endproperty
  a_cmp: assert property (p_cmp) else $error("upper result bits set");
  property p_eq;
    tk && pl && req_i.op == OP_ADDR_EQUAL_CMP
      |=> data_val_o[0] == ($past(req_i.opa) == $past(req_i.opb));
  endproperty
  a_eq: assert property (p_eq) else $error("equal compare wrong");
  // plain logic operands, so this compare is unsigned
  property p_lt;
    tk && pl && req_i.op == OP_ADDR_LESS_CMP
      |=> data_val_o[0] == ($past(req_i.opa) < $past(req_i.opb));
  endproperty
  a_lt: assert property (p_lt) else $error("less compare wrong");
  property p_z;
    tk && pl && req_i.op == OP_ADDR_IS_ZERO_TEST
      |=> data_val_o[0] == ($past(req_i.opa) == 32'h0);
  endproperty
  a_z: assert property (p_z) else $error("zero test wrong");
  property p_jmp;
    tk && req_i.op == OP_JUMP && req_i.dfmt == DF_REG
      |=> redirect_o && !link_wr_o && redirect_pc_o[31:1] == $past(req_i.opa[31:1]);
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump target wrong");
  property p_lnk;
    tk && req_i.op == OP_JUMP_LINK |=> link_wr_o
      && link_val_o == $past(req_i.pc) + ($past(req_i.short_insn) ? 32'h2 : 32'h4);
  endproperty
  a_lnk: assert property (p_lnk) else $error("link value wrong");
  property p_call;
    tk && req_i.op == OP_CALL |=> ctx_save_req_o && !req_ready_o && !redirect_o;
  endproperty
  a_call: assert property (p_call) else $error("call save missing");
  property p_ret;
    tk && req_i.op == OP_CALL_RETURN |=> ctx_restore_req_o && !link_wr_o;
  endproperty
  a_ret: assert property (p_ret) else $error("return restore missing");
  property p_loop;
    tk && pl && req_i.op == OP_LOOP && req_i.opa != 32'h0
      |=> addr_wr_o && redirect_o && addr_val_o == $past(req_i.opa) - 32'h1;
  endproperty
  a_loop: assert property (p_loop) else $error("loop count wrong");
endmodule : bacu_unit_sva

bind bacu_unit bacu_unit_sva u_sva (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
  .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
  .data_wr_o(data_wr_o), .data_val_o(data_val_o), .addr_wr_o(addr_wr_o),
  .addr_val_o(addr_val_o), .link_wr_o(link_wr_o), .link_val_o(link_val_o),
  .redirect_o(redirect_o), .redirect_pc_o(redirect_pc_o),
  .ctx_save_req_o(ctx_save_req_o), .ctx_restore_req_o(ctx_restore_req_o));

// ### verification/bacu_tb.sv
`timescale 1ns/10ps
module testbench
  import bacu_pkg::*;
;
  logic         clk, nrst, ce, vld, cdn, rdy, busy, dwr, awr, lwr, rd, sv, rs, exc, done;
  bacu_req_type rq;
  logic [31:0]  idr, rar, dv, av, lv, rpc;
  logic [1:0]   lc;
  int           err_count, check_count;
  localparam logic [31:0] PC = 32'h0000_1000;

  bacu_unit u_bacu_unit (.sys_clk_i(clk), .nrst_i(nrst), .ce_i(ce), .req_valid_i(vld),
    .req_i(rq), .implicit_data_register_i(idr), .return_address_register_i(rar),
    .ctx_done_i(cdn), .req_ready_o(rdy), .busy_o(busy), .data_wr_o(dwr), .data_val_o(dv),
    .addr_wr_o(awr), .addr_val_o(av), .link_wr_o(lwr), .link_val_o(lv), .redirect_o(rd),
    .redirect_pc_o(rpc), .ctx_save_req_o(sv), .ctx_restore_req_o(rs),
    .ctx_exception_o(exc), .done_o(done), .loop_cycles_o(lc));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk

  function automatic bacu_req_type mk(input bacu_op_type o, input bacu_dfmt_type f,
                                      input logic [31:0] a, input logic [23:0] d);
    bacu_req_type r;
    r = '0;
    r.op = o;
    r.dfmt = f;
    r.pc = PC;
    r.opa = a;
    r.opb = 32'h1;
    r.disp = d;
    r.bitpos = 5'h1f;
    return r;
  endfunction : mk

  // expected relative target: low w bits doubled, sign taken from bit w-1
  function automatic logic [31:0] rel(input logic [23:0] d, input int w);
    logic signed [23:0] t;
    t = d << (24 - w);
    t = t >>> (24 - w);
    return PC + {{7{t[23]}}, t, 1'b0};
  endfunction : rel

  // one request, held until the taking edge; outputs read once it has landed
  task automatic go(input bacu_req_type r);
    @(posedge clk);
    rq <= r;
    vld <= 1'b1;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask : go

  task automatic br(input bacu_req_type r, input logic t, input int w);
    go(r);
    chk("taken", {31'h0, t}, 32'(rd));
    if (t)
      chk("bpc", rel(r.disp, w), rpc);
  endtask : br

  task automatic t_cmp();
    bacu_op_type o[8] = '{OP_ADDR_EQUAL_CMP, OP_ADDR_NOTEQUAL_CMP, OP_ADDR_LESS_CMP,
      OP_ADDR_LESS_CMP, OP_ADDR_GREATER_EQUAL_CMP, OP_ADDR_LESS_CMP,
      OP_ADDR_IS_ZERO_TEST, OP_ADDR_IS_NONZERO_TEST};
    logic [31:0] a[8] = '{32'h1, 32'h1, 32'h0, 32'h8000_0000, 32'h8000_0000, 32'h2,
      32'h0, 32'h0};
    for (int i = 0; i < 8; i++)
    begin
      go(mk(o[i], DF_REG, a[i], 24'h0));
      chk("dwr", 32'h1, 32'(dwr));
      chk("dv", {31'h0, i[0] == 1'b0}, dv);
    end
    $display("t_cmp end");
  endtask : t_cmp

  task automatic t_jmp();
    bacu_req_type r;
    go(mk(OP_JUMP, DF_REL24, 32'h0, 24'h80_0003));
    chk("rpc", rel(24'h80_0003, 24), rpc);
    chk("lwr", 32'h0, 32'(lwr));
    chk("done", 32'h1, 32'(done));
    go(mk(OP_JUMP, DF_ABS24, 32'h0, 24'h12_3456));
    chk("rpc", 32'h0024_68ac, rpc);
    go(mk(OP_JUMP, DF_REG, 32'h2000_0101, 24'h0));
    chk("rpc", 32'h2000_0100, rpc);
    r = mk(OP_JUMP_LINK, DF_REL8, 32'h0, 24'h81);
    r.short_insn = 1'b1;
    go(r);
    chk("rpc", rel(24'h81, 8), rpc);
    chk("lv", PC + 32'h2, lv);
    go(mk(OP_JUMP_LINK, DF_ABS24, 32'h0, 24'h10));
    chk("lv", PC + 32'h4, lv);
    $display("t_jmp end");
  endtask : t_jmp

  // branch table: operand all-ones or one against one; bit i of tk says taken
  task automatic t_br();
    bacu_op_type o[16] = '{OP_BRANCH_IF_LESS_SIGNED, OP_BRANCH_IF_LESS_UNSIGNED,
      OP_BRANCH_IF_GE_SIGNED, OP_BRANCH_IF_GE_UNSIGNED, OP_BRANCH_IF_EQUAL,
      OP_BRANCH_IF_NOT_EQUAL, OP_BRANCH_IF_NEGATIVE, OP_BRANCH_IF_NOT_POSITIVE,
      OP_BRANCH_IF_POSITIVE, OP_BRANCH_IF_NOT_NEGATIVE, OP_BRANCH_IF_ADDR_EQUAL,
      OP_BRANCH_IF_ADDR_NONZERO, OP_BRANCH_IF_ADDR_ZERO, OP_BRANCH_IF_BIT_SET,
      OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_IF_ZERO};
    int w[16] = '{15, 15, 15, 15, 15, 15, 4, 4, 4, 4, 15, 4, 4, 15, 15, 8};
    logic [15:0] af = 16'h6a4f;
    logic [15:0] tk = 16'h2d59;
    bacu_req_type r;
    for (int i = 0; i < 16; i++)
    begin
      r = mk(o[i], w[i] == 15 ? DF_REL15 : (w[i] == 8 ? DF_REL8 : DF_REL4),
             af[i] ? 32'hffff_ffff : 32'h1, 24'h8);
      br(r, tk[i], w[i]);
    end
    r = mk(OP_BRANCH_IF_NONZERO, DF_REL8, 32'h0, 24'h8);
    r.use_implicit = 1'b1;
    br(r, 1'b1, 8);
    r.op = OP_BRANCH_IF_EQUAL;
    r.dfmt = DF_REL4;
    r.use_const = 1'b1;
    r.const4 = 4'hf;
    br(r, 1'b1, 4);
    go(mk(OP_BRANCH_NE_THEN_DECREMENT, DF_REL15, 32'h3, 24'h8));
    chk("dv", 32'h2, dv);
    br(mk(OP_BRANCH_NE_THEN_INCREMENT, DF_REL15, 32'h1, 24'h8), 1'b0, 15);
    chk("dv", 32'h2, dv);
    $display("t_br end");
  endtask : t_br

  // context op: the save or restore answer is stalled a cycle before it is granted
  task automatic ctx(input bacu_op_type o, input logic [31:0] e);
    go(mk(o, DF_ABS24, 32'h0, 24'h40));
    chk("creq", 32'h1, 32'(o == OP_CALL ? sv : rs));
    chk("busy", 32'h1, 32'(busy));
    chk("exc", {31'h0, o == OP_EXCEPTION_RETURN}, 32'(exc));
    @(posedge clk);
    cdn <= 1'b1;
    for (int i = 0; i <= 20; i++)
    begin
      @(posedge clk);
      cdn <= 1'b0;
      #1;
      if (done === 1'b1)
        break;
      if (i == 20)
      begin
        err_count++;
        complete_run();
      end
    end
    chk("rpc", e, rpc);
    chk("lwr", {31'h0, o == OP_CALL}, 32'(lwr));
  endtask : ctx

  task automatic t_loop();
    for (int i = 0; i < 3; i++)
    begin
      go(mk(OP_LOOP, DF_LOOP4, 32'(2 - i), 24'h4));
      chk("lc", {31'h0, i != 1}, 32'(lc));
      chk("awr", {31'h0, i != 2}, 32'(awr));
      if (i != 2)
        chk("rpc", PC - 32'h18, rpc);
    end
    go(mk(OP_LOOP, DF_REL15, 32'h5, 24'h4001));
    chk("rpc", rel(24'h4001, 15), rpc);
    chk("av", 32'h4, av);
    chk("lc", 32'h1, 32'(lc));
    $display("t_loop end");
  endtask : t_loop

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // reset for four cycles, then the scenarios in turn
  initial
  begin
    err_count = 0;
    check_count = 0;
    nrst = 1'b0;
    ce = 1'b1;
    vld = 1'b0;
    cdn = 1'b0;
    rq = '0;
    idr = 32'hffff_ffff;
    rar = 32'h3000_0043;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_cmp();
    t_jmp();
    t_br();
    ctx(OP_CALL, 32'h0000_0080);
    ctx(OP_CALL_RETURN, 32'h3000_0042);
    ctx(OP_EXCEPTION_RETURN, 32'h3000_0042);
    $display("t_ctx end");
    t_loop();
    complete_run();
  end
endmodule : testbench
